// file: verilog/ess_pkg.sv
// Constants and types shared by the enable/soft-start/reference sequencer
package ess_pkg;
   // Voltage-select code
   localparam int SEL_W = 5;
   localparam logic [4:0] CODE_OFF = 5'h1f;
   localparam int CODE_BASE = 30;
   localparam int BASE_MV = 800;
   localparam int STEP_MV = 25;
   localparam int MIN_MV = 800;
   localparam int MAX_MV = 1550;
   // Level and current widths (mV and nA)
   localparam int LVL_W = 11;
   localparam int CUR_W = 18;
   // Soft-start counter
   localparam int SS_W = 11;
   localparam int SS_LEN = 2048;
   localparam logic [10:0] SS_LAST = 11'h7ff;
   localparam logic [10:0] SS_ZERO = 11'h000;
   localparam logic [10:0] SS_ONE = 11'h001;
   // Ramp end point in percent of the reference
   localparam int RAMP_PCT = 140;
   localparam int PCT_DEN = 100;
   // Offset current start value in nA
   localparam int OFFSET_START_NA = 160000;
   // Synchroniser width: phase, enable, supply, five code bits
   localparam int SYNC_W = 8;

   typedef enum logic [1:0] {
      ESS_SHUT,
      ESS_SOFT,
      ESS_RUN
   } ess_state_t;
endpackage

// file: verilog/ess_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ess_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// file: verilog/ess_sequencer.sv
// Enable qualification, soft-start and stepped reference sequencer
`timescale 1ns/1ps
// Contract
// - Below supply-ok, PWM outputs stay high-impedance.
// - Stay shut down until enable comparator reports above threshold.
// - All-ones code forces shut-down; any other code allows restart.
// - Supply-ok, enable-ok, valid code start soft-start immediately.
// - Soft-start is 2048 phase pulses counted by 11-bit counter.
// - Ramp level rises linearly from zero to 140% of reference.
// - Offset current falls linearly from start value to zero.
// - Soft-start target is smaller of reference and ramp level.
// - Code changes are sampled only at phase-1 cycle starts; in shut-down any code but all-ones is loaded every clock.
// - Stable new code steps reference 25mV every two cycles.
// - Code change completes within 2N-1 to 2N switching cycles.
// - Code 11110 is 0.800V, each decrement adds 25mV.
module ess_sequencer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic supply_ok,
   input wire logic enable_ok,
   input wire logic phase_clk,
   input wire logic [4:0] voltage_select_pins,
   output logic pwm_oe_n,
   output logic [10:0] reference_level,
   output logic [11:0] soft_start_ramp_level,
   output logic [10:0] regulation_target,
   output logic [17:0] soft_start_offset_current,
   output logic soft_start_done
);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and phase-1 start detection

   logic [7:0] sync_q;
   logic phase_d_reg;

   // All pins are asynchronous to ref_clk
   ess_sync #(.W(ess_pkg::SYNC_W)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .d({phase_clk, enable_ok, supply_ok, voltage_select_pins}),
      .q(sync_q)
   );

   wire logic phase_s = sync_q[7];
   wire logic enable_s = sync_q[6];
   wire logic supply_s = sync_q[5];
   wire logic [4:0] sel_s = sync_q[4:0];

   // Edge seen on the synchronised copy, never on the first stage
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phase_d_reg <= 1'b0;
      end else begin
         phase_d_reg <= phase_s;
      end
   end

   wire logic tick = phase_s & ~phase_d_reg;

   ////////////////////////////////////////////////////////////////////////
   // Enable qualification and sequencing state

   ess_pkg::ess_state_t state_reg;
   ess_pkg::ess_state_t state_next;
   logic [10:0] ss_count_reg;

   wire logic code_off = (sel_s == ess_pkg::CODE_OFF);
   // all three conditions, no extra delay
   wire logic go = supply_s & enable_s & ~code_off;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ess_pkg::ESS_SHUT: begin
            if (go) begin
               state_next = ess_pkg::ESS_SOFT;
            end
         end
         ess_pkg::ESS_SOFT: begin
            if (!go) begin
               state_next = ess_pkg::ESS_SHUT;
            end else if (tick && ss_count_reg == ess_pkg::SS_LAST) begin
               state_next = ess_pkg::ESS_RUN;
            end
         end
         ess_pkg::ESS_RUN: begin
            if (!go) begin
               state_next = ess_pkg::ESS_SHUT;
            end
         end
         default: begin
            state_next = ess_pkg::ESS_SHUT;
         end
      endcase
   end

   // one count per phase pulse, 2048 in all
   wire logic [10:0] ss_count_next =
      (state_reg == ess_pkg::ESS_SOFT && go) ?
      (tick ? ss_count_reg + ess_pkg::SS_ONE : ss_count_reg) :
      ess_pkg::SS_ZERO;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg <= ess_pkg::ESS_SHUT;
         ss_count_reg <= ess_pkg::SS_ZERO;
      end else begin
         state_reg <= state_next;
         ss_count_reg <= ss_count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // On-the-fly code tracking

   logic [4:0] seen_code_reg;
   logic [4:0] ref_code_reg;
   logic step_wait_reg;

   // a code counts only if seen at two successive phase-1 starts
   wire logic stable = tick && (sel_s == seen_code_reg) && !code_off;
   // one step, then one cycle of rest
   // first step on confirmation gives the 2N-1..2N window
   wire logic do_step = stable && (sel_s != ref_code_reg) &&
      !step_wait_reg && (state_reg != ess_pkg::ESS_SHUT);
   wire logic [4:0] ref_code_step = (sel_s > ref_code_reg) ?
      ref_code_reg + 5'h01 : ref_code_reg - 5'h01;
   // Shut-down preloads the code so soft-start aims at the right level
   wire logic [4:0] ref_code_next =
      (state_reg == ess_pkg::ESS_SHUT) ?
      (code_off ? ref_code_reg : sel_s) :
      (do_step ? ref_code_step : ref_code_reg);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seen_code_reg <= ess_pkg::CODE_OFF;
         ref_code_reg <= ess_pkg::CODE_OFF;
         step_wait_reg <= 1'b0;
      end else begin
         ref_code_reg <= ref_code_next;
         if (tick) begin
            seen_code_reg <= sel_s;
            step_wait_reg <= do_step;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference, ramp, offset and target arithmetic

   // 25 mV per code step down from the base code
   wire logic [10:0] ref_mv_next = 11'(ess_pkg::BASE_MV +
      (ess_pkg::CODE_BASE - int'(ref_code_next)) * ess_pkg::STEP_MV);

   // count/2048 of 140% of the reference, 30-bit products
   wire logic [29:0] ramp_prod = 30'(ss_count_next) * 30'(ref_mv_next) *
      30'(ess_pkg::RAMP_PCT);
   // Ramp needs 12 bits: 140% of the top reference passes 2047 mV
   wire logic [11:0] ramp_soft =
      12'(ramp_prod / 30'(ess_pkg::PCT_DEN * ess_pkg::SS_LEN));
   wire logic [11:0] ramp_full = 12'((30'(ref_mv_next) *
      30'(ess_pkg::RAMP_PCT)) / 30'(ess_pkg::PCT_DEN));
   // zero at start, full 140% once running
   wire logic [11:0] ramp_next =
      (state_next == ess_pkg::ESS_RUN) ? ramp_full :
      (state_next == ess_pkg::ESS_SOFT) ? ramp_soft : 12'h000;

   // complementary fraction of the start current
   wire logic [29:0] offset_prod = 30'(ess_pkg::OFFSET_START_NA) *
      30'(ess_pkg::SS_LEN - int'(ss_count_next));
   wire logic [17:0] offset_next = (state_next == ess_pkg::ESS_SOFT) ?
      18'(offset_prod / 30'(ess_pkg::SS_LEN)) : 18'h00000;

   // lower of reference and ramp; ramp exceeds it once running
   wire logic [10:0] target_next =
      (state_next == ess_pkg::ESS_SHUT) ? 11'h000 :
      ((ramp_next < 12'(ref_mv_next)) ? 11'(ramp_next) : ref_mv_next);

   // supply loss drops straight to shut-down
   wire logic oe_n_next = (state_next == ess_pkg::ESS_SHUT);

   // Outputs registered from next values to save a cycle of lag
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pwm_oe_n <= 1'b1;
         reference_level <= 11'h000;
         soft_start_ramp_level <= 12'h000;
         regulation_target <= 11'h000;
         soft_start_offset_current <= 18'h00000;
         soft_start_done <= 1'b0;
      end else begin
         pwm_oe_n <= oe_n_next;
         reference_level <= ref_mv_next;
         soft_start_ramp_level <= ramp_next;
         regulation_target <= target_next;
         soft_start_offset_current <= offset_next;
         soft_start_done <= (state_next == ess_pkg::ESS_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   supply_low_hiz_a: assert property (
      !supply_s |=> pwm_oe_n && state_reg == ess_pkg::ESS_SHUT)
      else $error("PWM not high-impedance with supply low");

   enable_hold_a: assert property (
      state_reg == ess_pkg::ESS_SHUT && !enable_s
      |=> state_reg == ess_pkg::ESS_SHUT)
      else $error("Left shut-down without enable");

   code_off_shut_a: assert property (
      code_off |=> state_reg == ess_pkg::ESS_SHUT && pwm_oe_n)
      else $error("All-ones code did not shut down");

   start_now_a: assert property (
      state_reg == ess_pkg::ESS_SHUT && go
      |=> state_reg == ess_pkg::ESS_SOFT && !pwm_oe_n)
      else $error("Soft-start not begun at once");

   ss_count_step_a: assert property (
      state_reg == ess_pkg::ESS_SOFT && go && tick &&
      ss_count_reg != ess_pkg::SS_LAST
      |=> ss_count_reg == $past(ss_count_reg) + ess_pkg::SS_ONE &&
      state_reg == ess_pkg::ESS_SOFT)
      else $error("Soft-start count did not advance");

   ss_end_run_a: assert property (
      state_reg == ess_pkg::ESS_SOFT && go && tick &&
      ss_count_reg == ess_pkg::SS_LAST
      |=> soft_start_done && ss_count_reg == ess_pkg::SS_ZERO)
      else $error("Soft-start did not end after 2048 pulses");

   ramp_start_a: assert property (
      state_reg == ess_pkg::ESS_SHUT && go
      |=> soft_start_ramp_level == 12'h000 &&
      soft_start_offset_current == 18'(ess_pkg::OFFSET_START_NA))
      else $error("Ramp or offset wrong at soft-start entry");

   offset_zero_run_a: assert property (
      soft_start_done |-> soft_start_offset_current == 18'h00000 &&
      soft_start_ramp_level >= 12'(reference_level))
      else $error("Offset not zero or ramp low after soft-start");

   target_min_a: assert property (
      !pwm_oe_n |-> regulation_target <= reference_level &&
      12'(regulation_target) <= soft_start_ramp_level)
      else $error("Target above reference or ramp");

   code_sample_a: assert property (
      !tick && state_reg != ess_pkg::ESS_SHUT |=> $stable(ref_code_reg))
      else $error("Reference code moved between phase-1 starts");

   step_spacing_a: assert property (
      do_step |=> !do_step [*1] ##0 (ref_code_reg == $past(ref_code_step)))
      else $error("Reference step wrong");

   step_rest_a: assert property (
      tick && step_wait_reg && state_reg != ess_pkg::ESS_SHUT
      |=> $stable(ref_code_reg))
      else $error("Reference stepped in back-to-back cycles");

   ref_range_a: assert property (
      !pwm_oe_n |-> reference_level >= 11'(ess_pkg::MIN_MV) &&
      reference_level <= 11'(ess_pkg::MAX_MV))
      else $error("Reference outside decoded range");

   shut_clear_a: assert property (
      state_reg == ess_pkg::ESS_SHUT |-> ss_count_reg == ess_pkg::SS_ZERO
      ##1 (state_reg != ess_pkg::ESS_SHUT || pwm_oe_n))
      else $error("Shut-down did not clear counter or float PWM");

endmodule

// file: verif/ess_drv_model.sv
// Behavioural model of the external MOSFET drivers and reference DAC
`timescale 1ns/1ps
module ess_drv_model (
   input wire logic ref_clk,
   input wire logic pwm_oe_n,
   input wire logic [10:0] reference_level,
   output logic drivers_on,
   output logic [10:0] dac_mv
);
   // Drivers switch only while the PWM pins are driven, never on a float
   assign drivers_on = (pwm_oe_n === 1'b0);
   // DAC latches the code each clock; it settles no faster than that
   always_ff @(posedge ref_clk) begin
      dac_mv <= reference_level;
   end
endmodule

// file: verif/ess_sequencer_tb_top.sv
// Self-checking testbench for the enable, soft-start and reference block
`timescale 1ns/1ps
module ess_sequencer_tb_top;
   logic ref_clk, sys_rst, supply_ok, enable_ok, pwm_oe_n;
   logic phase_clk = 1'b0;
   logic soft_start_done, drivers_on, last_done, last_ph;
   logic [4:0] voltage_select_pins;
   logic [10:0] reference_level, regulation_target, dac_mv;
   logic [11:0] soft_start_ramp_level;
   logic [10:0] last_ref, minv;
   logic [17:0] soft_start_offset_current;
   logic [2:0] pcnt = 3'h0;
   int mismatches, cmp_count, n, ph;
   ess_sequencer ess_sequencer_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .supply_ok(supply_ok), .enable_ok(enable_ok), .phase_clk(phase_clk),
      .voltage_select_pins(voltage_select_pins), .pwm_oe_n(pwm_oe_n),
      .reference_level(reference_level),
      .soft_start_ramp_level(soft_start_ramp_level),
      .regulation_target(regulation_target),
      .soft_start_offset_current(soft_start_offset_current),
      .soft_start_done(soft_start_done));
   ess_drv_model ess_drv_model_i (.ref_clk(ref_clk), .pwm_oe_n(pwm_oe_n),
      .reference_level(reference_level), .drivers_on(drivers_on),
      .dac_mv(dac_mv));
   ////////////////////////////////////////////////////////////////////////
   // Clock and a six-cycle phase clock, three high and three low
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      pcnt <= (pcnt == 3'h5) ? 3'h0 : pcnt + 3'h1;
      phase_clk <= (pcnt < 3'h3);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic pins(input logic s, input logic e, input logic [4:0] c);
      @(posedge ref_clk);
      supply_ok <= s;
      enable_ok <= e;
      voltage_select_pins <= c;
      @(negedge ref_clk);
   endtask
   // Bounded wait for the PWM enable level; a hang ends the run
   task automatic wait_oe(input logic lvl);
      n = 0;
      while (pwm_oe_n !== lvl) begin
         @(negedge ref_clk);
         n++;
         if (n > 20) begin
            check(32'h0, 32'h1);
            print_verdict();
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Every reference move while running must be exactly one 25 mV step
   always @(negedge ref_clk) begin
      if (soft_start_done === 1'b1 && last_done === 1'b1 &&
          reference_level !== last_ref)
         check(32'((reference_level > last_ref) ? reference_level - last_ref
            : last_ref - reference_level), 32'h19);
      last_ref = reference_level;
      last_done = soft_start_done;
   end
   task automatic t_gate();
      pins(1'b0, 1'b1, 5'h1e);
      repeat (20) @(negedge ref_clk);
      check(32'(pwm_oe_n), 32'h1);
      check(32'(drivers_on), 32'h0);
      for (int c = 0; c < 31; c++) begin
         pins(1'b1, 1'b0, 5'(c));
         repeat (5) @(negedge ref_clk);
         check(32'(reference_level), 32'(800 + (30 - c) * 25));
         check(32'(pwm_oe_n), 32'h1);
      end
      pins(1'b1, 1'b1, 5'h1f);
      repeat (20) @(negedge ref_clk);
      check(32'(pwm_oe_n), 32'h1);
   endtask
   task automatic t_soft();
      pins(1'b1, 1'b1, 5'h1e);
      wait_oe(1'b0);
      check(32'(n <= 4), 32'h1);
      check(32'(soft_start_ramp_level), 32'h0);
      check(32'(soft_start_offset_current), 32'd160000);
      ph = 0;
      n = 0;
      while (soft_start_done !== 1'b1 && n < 13000) begin
         @(negedge ref_clk);
         n++;
         if (phase_clk && !last_ph)
            ph++;
         last_ph = phase_clk;
         minv = (soft_start_ramp_level < 12'(reference_level)) ?
            11'(soft_start_ramp_level) : reference_level;
         check(32'(regulation_target), 32'(minv));
      end
      check(32'(ph >= 2047 && ph <= 2049), 32'h1);
      check(32'(soft_start_ramp_level), 32'd1120);
      check(32'(soft_start_offset_current), 32'h0);
      check(32'(regulation_target), 32'd800);
   endtask
   task automatic t_step(input logic [4:0] c, input int mv, input int st);
      pins(1'b1, 1'b1, c);
      n = 0;
      while (reference_level !== 11'(mv) && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      check(32'(n > 12 * st - 6 && n <= 12 * st + 4), 32'h1);
      // Far-side DAC must pick up the final level one clock later
      @(negedge ref_clk);
      check(32'(dac_mv), 32'(mv));
   endtask
   task automatic t_glitch();
      // Align to a known phase count; the glitch lands between samples
      repeat (6) begin
         if (pcnt !== 3'h3)
            @(negedge ref_clk);
      end
      check(32'(pcnt), 32'h3);
      pins(1'b1, 1'b1, 5'h1a);
      pins(1'b1, 1'b1, 5'h1d);
      repeat (40) @(negedge ref_clk);
      check(32'(reference_level), 32'd825);
   endtask
   task automatic t_off();
      pins(1'b1, 1'b1, 5'h1f);
      wait_oe(1'b1);
      repeat (2) @(negedge ref_clk);
      check(32'(soft_start_done), 32'h0);
      check(32'(soft_start_ramp_level), 32'h0);
      check(32'(regulation_target), 32'h0);
      // Restart at the top code: the ramp must reach past 2047 mV
      pins(1'b1, 1'b1, 5'h00);
      wait_oe(1'b0);
      check(32'(soft_start_offset_current), 32'd160000);
      check(32'(soft_start_ramp_level), 32'h0);
      n = 0;
      while (soft_start_done !== 1'b1 && n < 13000) begin
         @(negedge ref_clk);
         n++;
      end
      check(32'(soft_start_done), 32'h1);
      check(32'(soft_start_ramp_level), 32'd2170);
      check(32'(regulation_target), 32'd1550);
      pins(1'b0, 1'b1, 5'h1e);
      wait_oe(1'b1);
      check(32'(drivers_on), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence; reset is held for three cycles to flush synchronisers
   initial begin
      mismatches = 0;
      cmp_count = 0;
      last_ph = 1'b0;
      sys_rst = 1'b1;
      supply_ok = 1'b0;
      enable_ok = 1'b0;
      voltage_select_pins = 5'h1f;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      check(32'(pwm_oe_n), 32'h1);
      t_gate();
      t_soft();
      t_step(5'h1a, 900, 4);
      t_step(5'h1d, 825, 3);
      t_glitch();
      t_off();
      print_verdict();
   end
endmodule
